// ===== rtl/autobaud_consts.svh
// Register map, field positions, reset values and rates of the auto-baud block
`ifndef AUTOBAUD_CONSTS_SVH
`define AUTOBAUD_CONSTS_SVH
`define AB_OFF_CTRL      12'h000
`define AB_OFF_DIV_LOW   12'h004
`define AB_OFF_DIV_HIGH  12'h008
`define AB_OFF_RX_DATA   12'h00c
`define AB_OFF_IRQ_STAT  12'h010
`define AB_OFF_IRQ_CLR   12'h014
`define AB_OFF_IRQ_EN    12'h018
`define AB_BIT_ENABLE    0
`define AB_BIT_WAKE      1
`define AB_BIT_WIDE      2
`define AB_BIT_HIGH      3
`define AB_BIT_OVF       4
`define AB_BIT_IDLE      5
`define AB_BIT_RFLAG     6
`define AB_EV_DONE       0
`define AB_EV_OVF        1
`define AB_EV_WAKE       2
`define AB_EV_W          3
`define AB_DIV_RESET     16'h0000
`define AB_DIV_MAX       16'hffff
`define AB_DIV_FIRST     16'h0001
`define AB_EDGE_LAST     3'h4
`define AB_PRE_SLOW      10'h200
`define AB_PRE_MID       10'h080
`define AB_PRE_FAST      10'h020
`define AB_SYNC_CHAR     8'h55
`endif

// ===== rtl/autobaud_pkg.sv
// Types of the auto-baud block
`include "autobaud_consts.svh"
package autobaud_pkg;
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_WAKE_LOW  = 3'b001,
    ST_WAKE_HIGH = 3'b010,
    ST_WAIT_START= 3'b011,
    ST_WAIT_EDGE = 3'b100,
    ST_COUNT     = 3'b101
  } ab_state_t;

  typedef struct packed {
    ab_state_t         fsm;
    logic              rx_prev;
    logic [9:0]        pre;
    logic [2:0]        edges;
    logic [15:0]       divisor;
    logic              ab_en;
    logic              wake_en;
    logic              wide;
    logic              high;
    logic              ovf;
    logic              rflag;
    logic              ridle;
    logic [`AB_EV_W-1:0] stat;
    logic [`AB_EV_W-1:0] en;
    logic              ack;
    logic [31:0]       rdata;
  } ab_regs_t;
endpackage

// ===== rtl/serial_autobaud_detector.sv
// Auto-baud measurement of a 55h sync character, APB register slave
//
// Behaviour
// - Receive line times the divisor counter across the 55h sync character.
// - Writing autobaud_enable high starts the calibration sequence.
// - Normal receive engine is held idle throughout calibration.
// - Counting starts at first rising edge after the start bit.
// - Fifth rising edge stops count, clears enable, sets receive_flag.
// - Reading receive data clears receive_flag; software discards the value.
// - Counting clock Fosc/512, /128 or /32 from wide and high-speed bits.
// - Divisor high and low act as one 16-bit counter.
// - Counter steps once per counting-clock tick, over eight bit times.
// - With wake-on-break, measurement uses the character after the break.
// - Count starts at 1; software subtracts 1 afterwards.
// - Overflow sets autobaud_overflow and receive_flag; counting continues.
// - receive_idle reads 0 during calibration, 1 after fifth edge.
`timescale 1ns/10ps
`default_nettype none
`include "autobaud_consts.svh"
module serial_autobaud_detector
  import autobaud_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Serial line
  input  wire logic        RX_IN,
  // Status
  output logic             RX_HOLD_OUT,
  output logic             IRQ_OUT
);

  ab_regs_t r_reg;
  ab_regs_t r_next;

  logic        access;
  logic        done;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        rise;
  logic        fall;
  logic        tick;
  logic [9:0]  pre_lim;
  logic [31:0] rmux;
  logic [`AB_EV_W-1:0] ev;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  assign access = PSEL_IN & PENABLE_IN;
  assign done   = access & r_reg.ack;
  assign wr     = done & PWRITE_IN;
  assign rd     = done & ~PWRITE_IN;
  assign mapped = (PADDR_IN == `AB_OFF_CTRL) |
                  (PADDR_IN == `AB_OFF_DIV_LOW) |
                  (PADDR_IN == `AB_OFF_DIV_HIGH) |
                  (PADDR_IN == `AB_OFF_RX_DATA) |
                  (PADDR_IN == `AB_OFF_IRQ_STAT) |
                  (PADDR_IN == `AB_OFF_IRQ_CLR) |
                  (PADDR_IN == `AB_OFF_IRQ_EN);
  assign rise   = RX_IN & ~r_reg.rx_prev;
  assign fall   = ~RX_IN & r_reg.rx_prev;

  // Counting clock: one tick per 512, 128 or 32 clocks from the wide and high bits
  always_comb begin
    case ({r_reg.wide, r_reg.high})
      2'b00:   pre_lim = `AB_PRE_SLOW;
      2'b11:   pre_lim = `AB_PRE_FAST;
      default: pre_lim = `AB_PRE_MID;
    endcase
  end
  assign tick = (r_reg.pre == pre_lim - 10'h001);

  // Read multiplexer
  always_comb begin
    rmux = 32'h0000_0000;
    case (PADDR_IN)
      `AB_OFF_CTRL: begin
        rmux[`AB_BIT_ENABLE] = r_reg.ab_en;
        rmux[`AB_BIT_WAKE]   = r_reg.wake_en;
        rmux[`AB_BIT_WIDE]   = r_reg.wide;
        rmux[`AB_BIT_HIGH]   = r_reg.high;
        rmux[`AB_BIT_OVF]    = r_reg.ovf;
        rmux[`AB_BIT_IDLE]   = r_reg.ridle;
        rmux[`AB_BIT_RFLAG]  = r_reg.rflag;
      end
      `AB_OFF_DIV_LOW:  rmux[7:0] = r_reg.divisor[7:0];
      `AB_OFF_DIV_HIGH: rmux[7:0] = r_reg.divisor[15:8];
      `AB_OFF_IRQ_STAT: rmux[`AB_EV_W-1:0] = r_reg.stat;
      `AB_OFF_IRQ_EN:   rmux[`AB_EV_W-1:0] = r_reg.en;
      default:          rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    r_next = r_reg;
    ev = '0;
    r_next.rx_prev = RX_IN;

    // APB: one wait state, data latched in the first access cycle
    if (access & ~r_reg.ack) begin
      r_next.ack   = 1'b1;
      r_next.rdata = rmux;
    end else begin
      r_next.ack = 1'b0;
    end

    // Software writes
    if (wr) begin
      case (PADDR_IN)
        `AB_OFF_CTRL: begin
          r_next.wake_en = PWDATA_IN[`AB_BIT_WAKE];
          r_next.wide    = PWDATA_IN[`AB_BIT_WIDE];
          r_next.high    = PWDATA_IN[`AB_BIT_HIGH];
          if (!PWDATA_IN[`AB_BIT_OVF])
            r_next.ovf = 1'b0;
          if (PWDATA_IN[`AB_BIT_ENABLE] && r_reg.fsm == ST_IDLE) begin
            r_next.ab_en   = 1'b1;
            r_next.divisor = `AB_DIV_RESET;
            r_next.ridle   = 1'b0;
            r_next.fsm     = PWDATA_IN[`AB_BIT_WAKE] ?
                             ST_WAKE_LOW : ST_WAIT_START;
          end else if (!PWDATA_IN[`AB_BIT_ENABLE]) begin
            r_next.ab_en = 1'b0;
            r_next.ridle = 1'b1;
            r_next.fsm   = ST_IDLE;
          end
        end
        `AB_OFF_DIV_LOW:
          if (r_reg.fsm == ST_IDLE)
            r_next.divisor[7:0] = PWDATA_IN[7:0];
        `AB_OFF_DIV_HIGH:
          if (r_reg.fsm == ST_IDLE)
            r_next.divisor[15:8] = PWDATA_IN[7:0];
        `AB_OFF_IRQ_CLR:  r_next.stat = r_reg.stat & ~PWDATA_IN[`AB_EV_W-1:0];
        `AB_OFF_IRQ_EN:   r_next.en = PWDATA_IN[`AB_EV_W-1:0];
        default: ;
      endcase
    end
    if (rd && PADDR_IN == `AB_OFF_RX_DATA)
      r_next.rflag = 1'b0;

    // Measurement sequence; hardware sets below win over software clears
    case (r_reg.fsm)
      ST_IDLE: ;
      ST_WAKE_LOW:
        if (fall) begin
          r_next.rflag = 1'b1;
          ev[`AB_EV_WAKE] = 1'b1;
          r_next.fsm = ST_WAKE_HIGH;
        end
      ST_WAKE_HIGH:
        if (rise) begin
          r_next.wake_en = 1'b0;
          r_next.fsm = ST_WAIT_START;
        end
      ST_WAIT_START:
        if (fall)
          r_next.fsm = ST_WAIT_EDGE;
      ST_WAIT_EDGE:
        if (rise) begin
          r_next.divisor = `AB_DIV_FIRST;
          r_next.pre   = 10'h000;
          r_next.edges = 3'h0;
          r_next.fsm   = ST_COUNT;
        end
      ST_COUNT: begin
        r_next.pre = tick ? 10'h000 : r_reg.pre + 10'h001;
        if (rise && r_reg.edges == `AB_EDGE_LAST - 3'h1) begin
          r_next.ab_en = 1'b0;
          r_next.rflag = 1'b1;
          r_next.ridle = 1'b1;
          ev[`AB_EV_DONE] = 1'b1;
          r_next.fsm = ST_IDLE;
        end else begin
          if (rise)
            r_next.edges = r_reg.edges + 3'h1;
          if (tick) begin
            r_next.divisor = r_reg.divisor + 16'h0001;
            if (r_reg.divisor == `AB_DIV_MAX) begin
              r_next.ovf  = 1'b1;
              r_next.rflag = 1'b1;
              ev[`AB_EV_OVF] = 1'b1;
            end
          end
        end
      end
      default: r_next.fsm = ST_IDLE;
    endcase
    r_next.stat = r_next.stat | ev;
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      r_reg         <= '0;
      r_reg.fsm     <= ST_IDLE;
      r_reg.rx_prev <= 1'b1;
      r_reg.ridle   <= 1'b1;
      r_reg.divisor <= `AB_DIV_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign PRDATA_OUT  = r_reg.rdata;
  assign PREADY_OUT  = done;
  assign PSLVERR_OUT = done & ~mapped;
  assign RX_HOLD_OUT = (r_reg.fsm != ST_IDLE);
  assign IRQ_OUT     = |(r_reg.stat & r_reg.en);

  start_clears_a: assert property (
    (wr && PADDR_IN == `AB_OFF_CTRL && PWDATA_IN[`AB_BIT_ENABLE]
     && r_reg.fsm == ST_IDLE) |=> (r_reg.divisor == 16'h0000 && r_reg.ab_en))
    else $error("divisor not cleared at start");

  first_edge_a: assert property (
    (r_reg.fsm == ST_WAIT_EDGE && rise) |=>
      (r_reg.divisor == 16'h0001 && r_reg.fsm == ST_COUNT))
    else $error("count did not start at 1");

  fifth_edge_a: assert property (
    (r_reg.fsm == ST_COUNT && rise && r_reg.edges == 3'h3) |=>
      (!r_reg.ab_en && r_reg.rflag && r_reg.ridle && $stable(r_reg.divisor)))
    else $error("fifth edge did not finish calibration");

  idle_hold_a: assert property (
    (r_reg.fsm != ST_IDLE) |-> (!r_reg.ridle && RX_HOLD_OUT))
    else $error("receive idle or hold wrong in calibration");

  tick_rate_a: assert property (
    (r_reg.fsm == ST_COUNT && !r_reg.wide && !r_reg.high && tick)
      |-> r_reg.pre == 10'h1ff)
    else $error("slow counting clock wrong");

  overflow_a: assert property (
    (r_reg.fsm == ST_COUNT && tick && r_reg.divisor == 16'hffff &&
     !(rise && r_reg.edges == 3'h3)) |=>
      (r_reg.ovf && r_reg.rflag && r_reg.divisor == 16'h0000 &&
       r_reg.fsm == ST_COUNT))
    else $error("overflow not flagged or counting stopped");

  read_clear_a: assert property (
    (rd && PADDR_IN == `AB_OFF_RX_DATA && r_reg.fsm == ST_IDLE) |=>
      !r_reg.rflag)
    else $error("receive data read left flag set");

  wake_first_a: assert property (
    (r_reg.fsm == ST_WAKE_LOW || r_reg.fsm == ST_WAKE_HIGH) |=>
      $stable(r_reg.divisor))
    else $error("counted during break");

  ready_wait_a: assert property (
    (access && !r_reg.ack) |-> !PREADY_OUT ##1 (!access || PREADY_OUT))
    else $error("APB wait state wrong");

  no_early_count_a: assert property (
    (r_reg.fsm == ST_WAIT_START || (r_reg.fsm == ST_WAIT_EDGE && !rise))
      |=> $stable(r_reg.divisor))
    else $error("divisor moved before first rising edge");

  tick_step_a: assert property (
    (r_reg.fsm == ST_COUNT && tick && !(rise && r_reg.edges == 3'h3))
      |=> r_reg.divisor == $past(r_reg.divisor) + 16'h0001)
    else $error("divisor did not step on counting tick");

  tick_only_a: assert property (
    (r_reg.fsm == ST_COUNT && !tick) |=> $stable(r_reg.divisor))
    else $error("divisor stepped without counting tick");

  mid_rate_a: assert property (
    (r_reg.fsm == ST_COUNT && (r_reg.wide ^ r_reg.high) && tick)
      |-> r_reg.pre == 10'h07f)
    else $error("middle counting clock wrong");

  fast_rate_a: assert property (
    (r_reg.fsm == ST_COUNT && r_reg.wide && r_reg.high && tick)
      |-> r_reg.pre == 10'h01f)
    else $error("fast counting clock wrong");

  wake_end_a: assert property (
    (r_reg.fsm == ST_WAKE_HIGH && rise) |=>
      (!r_reg.wake_en && r_reg.fsm == ST_WAIT_START))
    else $error("break end did not arm the measurement");

  wake_event_a: assert property (
    (r_reg.fsm == ST_WAKE_LOW && fall) |=>
      (r_reg.rflag && r_reg.stat[`AB_EV_WAKE]))
    else $error("wake event not flagged");

endmodule // serial_autobaud_detector
`default_nettype wire

// ===== tb/sync_sender.sv
// Remote transmitter model sending one sync character or one break per request
`timescale 1ns/10ps
`default_nettype none
`include "autobaud_consts.svh"
module sync_sender (
  // Clock and control
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic        brk_in,
  input  wire logic [15:0] bit_cycles_in,
  // Serial line, idle high, and busy flag
  output logic             rx_out,
  output logic             busy_out
);
  logic [9:0] frame;

  initial begin
    rx_out   = 1'b1;
    busy_out = 1'b0;
    frame    = 10'h000;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        busy_out <= 1'b1;
        // Break is a start bit and eight zero data bits, then a high stop bit
        frame = brk_in ? {1'b1, 8'h00, 1'b0} :
                         {1'b1, `AB_SYNC_CHAR, 1'b0};
        // Start bit, data LSB first, stop bit
        for (int i = 0; i < 10; i++) begin
          rx_out <= frame[i];
          repeat (bit_cycles_in) @(posedge clk_in);
        end
        busy_out <= 1'b0;
      end
    end
  end
endmodule // sync_sender
`default_nettype wire

// ===== tb/serial_autobaud_detector_tb_top.sv
// Testbench of the auto-baud detector
`timescale 1ns/10ps
`default_nettype none
`include "autobaud_consts.svh"
module serial_autobaud_detector_tb_top;
  localparam int LIMIT = 40000;
  localparam int T_TAB [4] = '{1030, 260, 260, 66};
  localparam int P_TAB [4] = '{`AB_PRE_SLOW, `AB_PRE_MID, `AB_PRE_MID,
                               `AB_PRE_FAST};
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx;
  logic        hold;
  logic        irq;
  logic        go;
  logic        busy;
  logic        brk;
  logic [15:0] bit_cycles;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          n_compared;
  int          cycles;
  int          exp_div;

  serial_autobaud_detector uut (
    .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .RX_IN(rx), .RX_HOLD_OUT(hold), .IRQ_OUT(irq)
  );

  sync_sender sender (
    .clk_in(clk), .go_in(go), .brk_in(brk), .bit_cycles_in(bit_cycles),
    .rx_out(rx), .busy_out(busy)
  );

  always #2 clk = ~clk;

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One frame from the far-end model, break or sync
  task automatic send(input logic b);
    @(posedge clk);
    go  <= 1'b1;
    brk <= b;
    @(posedge clk);
    go  <= 1'b0;
    brk <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    go = 1'b0;
    brk = 1'b0;
    bit_cycles = 16'h0042;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `AB_OFF_CTRL, 32'h0);
    check("ctrl reset", 32'h20, rd);
    check("mapped error", 32'h0, {31'h0, err});
    apb(1'b0, 12'h01c, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    apb(1'b1, `AB_OFF_IRQ_EN, 32'h1);
    // Divisor writes refused while armed, taken when idle; abort
    apb(1'b1, `AB_OFF_DIV_LOW, 32'h5a);
    apb(1'b1, `AB_OFF_CTRL, 32'h1);
    apb(1'b1, `AB_OFF_DIV_LOW, 32'ha5);
    apb(1'b0, `AB_OFF_DIV_LOW, 32'h0);
    check("div cleared", 32'h0, rd);
    apb(1'b1, `AB_OFF_CTRL, 32'h0);
    @(negedge clk);
    check("hold abort", 32'h0, {31'h0, hold});
    apb(1'b1, `AB_OFF_DIV_HIGH, 32'h3c);
    apb(1'b0, `AB_OFF_DIV_HIGH, 32'h0);
    check("div high idle", 32'h3c, rd);
    apb(1'b0, `AB_OFF_CTRL, 32'h0);
    check("ctrl abort", 32'h20, rd);
    // Every counting-clock selection, rate chosen to be measurable
    for (int m = 0; m < 4; m++) begin
      bit_cycles <= 16'(T_TAB[m]);
      exp_div = 8 * T_TAB[m] / P_TAB[m] + 1;
      apb(1'b1, `AB_OFF_CTRL, 32'h1 | (m << 2));
      @(negedge clk);
      check("hold during", 32'h1, {31'h0, hold});
      send(1'b0);
      apb(1'b0, `AB_OFF_CTRL, 32'h0);
      check("ctrl busy", 32'h1 | (m << 2), rd);
      while (busy !== 1'b0) @(posedge clk);
      repeat (3) @(posedge clk);
      apb(1'b0, `AB_OFF_CTRL, 32'h0);
      check("ctrl done", 32'h60 | (m << 2), rd);
      apb(1'b0, `AB_OFF_DIV_LOW, 32'h0);
      check("div low", 32'(exp_div & 8'hff), rd);
      apb(1'b0, `AB_OFF_DIV_HIGH, 32'h0);
      check("div high", 32'(exp_div >> 8), rd);
      apb(1'b0, `AB_OFF_IRQ_STAT, 32'h0);
      check("status done", 32'h1, rd);
      @(negedge clk);
      check("irq set", 32'h1, {31'h0, irq});
      check("hold after", 32'h0, {31'h0, hold});
      apb(1'b0, `AB_OFF_RX_DATA, 32'h0);
      apb(1'b0, `AB_OFF_CTRL, 32'h0);
      check("flag cleared", 32'h20 | (m << 2), rd);
      apb(1'b1, `AB_OFF_IRQ_CLR, 32'h1);
      @(negedge clk);
      check("irq cleared", 32'h0, {31'h0, irq});
    end
    // Wake on break: measure the character after the break
    apb(1'b1, `AB_OFF_CTRL, 32'hf);
    send(1'b1);
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    apb(1'b0, `AB_OFF_CTRL, 32'h0);
    check("ctrl after break", 32'h4d, rd);
    apb(1'b0, `AB_OFF_IRQ_STAT, 32'h0);
    check("wake status", 32'h4, rd);
    apb(1'b0, `AB_OFF_RX_DATA, 32'h0);
    check("rx data", 32'h0, rd);
    send(1'b0);
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    apb(1'b0, `AB_OFF_CTRL, 32'h0);
    check("ctrl wake done", 32'h6c, rd);
    apb(1'b0, `AB_OFF_DIV_LOW, 32'h0);
    check("wake div low", 32'(exp_div & 8'hff), rd);
    wrap_up();
  end
endmodule // serial_autobaud_detector_tb_top
`default_nettype wire
